/* File: design/ssc_pkg.sv */
// What this block does
// - The first eight bits of each frame, most significant first, are the operation code that picks the command.
// - Codes decode as register write X101X0XX, register read X10010XX, memory write 0001XXXX, erase 001XXXXX, memory read X0001XXX, block write 1001XXXX, block erase 101XXXXX.
// - The comparator pin follows object temperature against the potentiometer threshold when that source is chosen.
// - The relay pin follows ambient temperature against the stored threshold when that source is chosen.
// - Ambient and object results can be read over the port at any time while measuring goes on.
// - A frame is 32 bits: code byte, address byte, then 16 data bits, and the device is always slave.
// - A frame opens on chip select falling and closes on its rise after 32 clocks; data in is sampled on rising edges.
// - On a write the output echoes code, address and first data byte eight clocks late; an early chip select rise aborts.
// - On a read the output carries the code and then the data with no address, data valid from the 17th rising edge.
`default_nettype none
package ssc_pkg;
   // ---------------------------------------------------------------
   // Frame layout
   // ---------------------------------------------------------------
   localparam int FRAME_BITS = 32;
   localparam int CODE_BITS  = 8;
   localparam int ADDR_BITS  = 8;
   localparam int DATA_BITS  = 16;
   localparam int ECHO_DELAY = 8;
   localparam int READ_START = 16;
   localparam logic [5:0] CNT_CODE = 6'h08;
   localparam logic [5:0] CNT_ADDR = 6'h10;
   localparam logic [5:0] CNT_END  = 6'h20;
   // ---------------------------------------------------------------
   // Result addresses and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  ADDR_OBJECT  = 8'h03;
   localparam logic [7:0]  ADDR_AMBIENT = 8'h04;
   localparam logic [15:0] DATA_RESET   = 16'h0000;
   localparam logic [7:0]  BYTE_RESET   = 8'h00;

   typedef enum logic [2:0] {
      CMD_NONE, CMD_REG_WRITE, CMD_REG_READ, nvm_write_cmd, nvm_erase_cmd,
      nvm_read_cmd, nvm_block_write_cmd, nvm_block_erase_cmd
   } ssc_cmd_type;

   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} ssc_state_type;

   // Decoder for the operation byte, shared by frame and commit logic
   function automatic ssc_cmd_type ssc_decode(input logic [7:0] c);
      if (c[6:4] == 3'b101 && c[2] == 1'b0) return CMD_REG_WRITE;
      if (c[6:2] == 5'b10010) return CMD_REG_READ;
      if (c[7:4] == 4'b0001) return nvm_write_cmd;
      if (c[7:5] == 3'b001) return nvm_erase_cmd;
      if (c[6:3] == 4'b0001) return nvm_read_cmd;
      if (c[7:4] == 4'b1001) return nvm_block_write_cmd;
      if (c[7:5] == 3'b101) return nvm_block_erase_cmd;
      return CMD_NONE;
   endfunction
endpackage
`default_nettype wire

/* File: design/ssc_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser for a bundle of pin levels
module ssc_sync #(
   parameter int W = 3
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Levels
   input  wire logic [W-1:0] async_i,
   output var  logic [W-1:0] sync_o
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync;

   // --------------------------------------------------------------
   // First flop feeds only the second
   // --------------------------------------------------------------
   always_comb begin
      next_meta = async_i;
      next_sync = meta;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= next_meta;
         sync_o <= next_sync;
      end
   end
endmodule // ssc_sync
`default_nettype wire

/* File: design/ssc_port.sv */
`timescale 1ns/10ps
`default_nettype none
// Serial command port: oversamples the master's slow clock on CLK_I
module ssc_port (
   // Clock and reset
   input  wire logic                 CLK_I,
   input  wire logic                 RST_N_I,
   // Serial pins to and from the master
   input  wire logic                 CS_N_I,
   input  wire logic                 SCLK_I,
   input  wire logic                 SDI_I,
   output var  logic                 SDO_O,
   output var  logic                 SDO_OE_N_O,
   // Measurement results and thresholds
   input  wire logic [15:0]          OBJECT_I,
   input  wire logic [15:0]          AMBIENT_I,
   input  wire logic [15:0]          REG_RDATA_I,
   input  wire logic [15:0]          NVM_RDATA_I,
   input  wire logic [11:0]          POT_THRESH_I,
   input  wire logic [11:0]          NVM_THRESH_I,
   input  wire logic                 COMP_POT_SEL_I,
   input  wire logic                 REL_NVM_SEL_I,
   // Command out to register file and memory
   output var  ssc_pkg::ssc_cmd_type CMD_O,
   output var  logic [7:0]           ADDR_O,
   output var  logic [15:0]          WDATA_O,
   output var  logic                 CMD_STB_O,
   // Comparator pins
   output var  logic                 COMP_O,
   output var  logic                 RELAY_O
);
   import ssc_pkg::*;

   logic [2:0]          pins;
   logic                cs_n, sclk, sdi;
   logic                sclk_d, next_sclk_d;
   ssc_state_type       state, next_state;
   logic [5:0]          cnt, next_cnt;
   logic [31:0]         shreg, next_shreg;
   logic [15:0]         rdata, next_rdata;
   logic [7:0]          echo_code, next_echo_code;
   logic                sdo, next_sdo, sdo_oe_n, next_sdo_oe_n;
   ssc_cmd_type         cmd, next_cmd;
   logic [7:0]          addr, next_addr;
   logic [15:0]         wdata, next_wdata;
   logic                stb, next_stb, comp, next_comp, relay, next_relay;
   logic                rise, fall;
   ssc_cmd_type         cur_cmd;

   // --------------------------------------------------------------
   // Pin synchronisers; the slow SCLK makes oversampling safe
   // --------------------------------------------------------------
   // Chip select enters inverted, so the flops' cleared state reads as
   // deselected; otherwise reset release would fake a frame start
   ssc_sync #(.W(3)) u_sync (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .async_i ({~CS_N_I, SCLK_I, SDI_I}),
      .sync_o  (pins)
   );
   assign cs_n = ~pins[2];
   assign sclk = pins[1];
   assign sdi  = pins[0];
   assign rise = sclk & ~sclk_d & ~cs_n;
   assign fall = ~sclk & sclk_d & ~cs_n;
   assign cur_cmd = ssc_decode(shreg[31:24]);

   // --------------------------------------------------------------
   // Frame engine
   // --------------------------------------------------------------
   always_comb begin
      next_sclk_d    = sclk;
      next_state     = state;
      next_cnt       = cnt;
      next_shreg     = shreg;
      next_rdata     = rdata;
      next_echo_code = echo_code;
      next_sdo       = sdo;
      next_sdo_oe_n  = sdo_oe_n;
      next_cmd       = cmd;
      next_addr      = addr;
      next_wdata     = wdata;
      next_stb       = 1'b0;
      case (state)
         ST_IDLE: begin
            next_sdo_oe_n = 1'b1;
            next_cnt      = '0;
            if (!cs_n) begin
               next_state    = ST_SHIFT;
               next_sdo_oe_n = 1'b0;
               next_sdo      = 1'b0;
            end
         end
         ST_SHIFT: begin
            if (cs_n) begin
               // Early rise aborts: nothing is committed
               next_state = ST_IDLE;
            end else if (rise) begin
               // Shift in MSB first on rising edges
               next_shreg = {shreg[30:0], sdi};
               next_cnt   = cnt + 6'h01;
               if (cnt + 6'h01 == CNT_CODE)
                  next_echo_code = {shreg[6:0], sdi};
               if (cnt + 6'h01 == CNT_END)
                  next_state = ST_DONE;
            end else if (fall) begin
               // Output changes on falling edge, stable at next rise
               if (cnt == CNT_ADDR) begin
                  // Snapshot results now so a read sees a coherent word
                  case (shreg[7:0])
                     ADDR_OBJECT:  next_rdata = OBJECT_I;
                     ADDR_AMBIENT: next_rdata = AMBIENT_I;
                     default:      next_rdata = (ssc_decode(shreg[15:8]) == nvm_read_cmd) ? NVM_RDATA_I : REG_RDATA_I;
                  endcase
               end
               if (cnt < CNT_CODE[5:0] + 6'h08) begin
                  // First echo bits: code comes out after 8 clocks
                  next_sdo = (cnt < CNT_CODE) ? 1'b0 : echo_code[7 - (cnt - CNT_CODE)];
               end else if (ssc_decode(echo_code) == CMD_REG_READ ||
                            ssc_decode(echo_code) == nvm_read_cmd) begin
                  // Read: data follows the code, address skipped
                  next_sdo = (cnt == CNT_ADDR) ?
                             ((shreg[7:0] == ADDR_OBJECT) ? OBJECT_I[15] :
                              (shreg[7:0] == ADDR_AMBIENT) ? AMBIENT_I[15] :
                              ((ssc_decode(shreg[15:8]) == nvm_read_cmd) ? NVM_RDATA_I[15] : REG_RDATA_I[15]))
                             : rdata[15 - (cnt - CNT_ADDR)];
               end else begin
                  // Write: delayed echo of the shift stream
                  next_sdo = shreg[ECHO_DELAY - 1];
               end
            end
         end
         ST_DONE: begin
            if (cs_n) begin
               next_state    = ST_IDLE;
               next_sdo_oe_n = 1'b1;
               if (cur_cmd != CMD_NONE &&
                   cur_cmd != CMD_REG_READ && cur_cmd != nvm_read_cmd) begin
                  next_cmd   = cur_cmd;
                  next_addr  = shreg[23:16];
                  next_wdata = shreg[15:0];
                  next_stb   = 1'b1;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sclk_d    <= 1'b0;
         state     <= ST_IDLE;
         cnt       <= '0;
         shreg     <= '0;
         rdata     <= DATA_RESET;
         echo_code <= BYTE_RESET;
         sdo       <= 1'b0;
         sdo_oe_n  <= 1'b1;
         cmd       <= CMD_NONE;
         addr      <= BYTE_RESET;
         wdata     <= DATA_RESET;
         stb       <= 1'b0;
      end else begin
         sclk_d    <= next_sclk_d;
         state     <= next_state;
         cnt       <= next_cnt;
         shreg     <= next_shreg;
         rdata     <= next_rdata;
         echo_code <= next_echo_code;
         sdo       <= next_sdo;
         sdo_oe_n  <= next_sdo_oe_n;
         cmd       <= next_cmd;
         addr      <= next_addr;
         wdata     <= next_wdata;
         stb       <= next_stb;
      end
   end

   // --------------------------------------------------------------
   // Comparators; hold last value when source not selected
   // --------------------------------------------------------------
   always_comb begin
      next_comp  = comp;
      next_relay = relay;
      if (COMP_POT_SEL_I)
         next_comp = (OBJECT_I[15:4] > POT_THRESH_I);
      if (REL_NVM_SEL_I)
         next_relay = (AMBIENT_I[15:4] > NVM_THRESH_I);
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         comp  <= 1'b0;
         relay <= 1'b0;
      end else begin
         comp  <= next_comp;
         relay <= next_relay;
      end
   end

   assign SDO_O      = sdo;
   assign SDO_OE_N_O = sdo_oe_n;
   assign CMD_O      = cmd;
   assign ADDR_O     = addr;
   assign WDATA_O    = wdata;
   assign CMD_STB_O  = stb;
   assign COMP_O     = comp;
   assign RELAY_O    = relay;
endmodule // ssc_port
`default_nettype wire

/* File: test/ssc_port_props.sv */
`timescale 1ns/10ps
`default_nettype none
module ssc_port_props (
   // Clock and frame pins
   input wire logic                 CLK_I,
   input wire logic                 RST_N_I,
   input wire logic                 CS_N_I,
   input wire logic                 SDO_OE_N_O,
   // Results and comparators
   input wire logic [15:0]          OBJECT_I,
   input wire logic [15:0]          AMBIENT_I,
   input wire logic [11:0]          POT_THRESH_I,
   input wire logic [11:0]          NVM_THRESH_I,
   input wire logic                 COMP_POT_SEL_I,
   input wire logic                 REL_NVM_SEL_I,
   input wire logic                 COMP_O,
   input wire logic                 RELAY_O,
   // Command side
   input wire ssc_pkg::ssc_cmd_type CMD_O,
   input wire logic                 CMD_STB_O
);
   import ssc_pkg::*;
   // -----------------------------
   // Port checks, one clock domain
   // -----------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   stb_pulse_a: assert property (CMD_STB_O |=> !CMD_STB_O)
      else $error("strobe longer than one cycle");
   stb_after_cs_a: assert property (CMD_STB_O |-> CS_N_I && $past(CS_N_I, 2))
      else $error("strobe while frame open");
   oe_idle_a: assert property (CS_N_I [*5] |-> SDO_OE_N_O)
      else $error("output driven outside frame");
   oe_drive_a: assert property (!CS_N_I [*5] |-> !SDO_OE_N_O)
      else $error("output not driven in frame");
   cmd_change_a: assert property ($changed(CMD_O) |-> ##[0:1] (CMD_STB_O || $past(CMD_STB_O)))
      else $error("command moved without strobe");
   stb_write_a: assert property (CMD_STB_O |-> ##[0:1]
      (CMD_O != CMD_NONE && CMD_O != CMD_REG_READ && CMD_O != nvm_read_cmd))
      else $error("strobe with no write command");
   comp_pot_a: assert property ((COMP_POT_SEL_I && $stable(OBJECT_I) && $stable(POT_THRESH_I)) [*5]
      |-> COMP_O == (OBJECT_I[15:4] > POT_THRESH_I)) else $error("comparator wrong");
   relay_nvm_a: assert property ((REL_NVM_SEL_I && $stable(AMBIENT_I) && $stable(NVM_THRESH_I)) [*5]
      |-> RELAY_O == (AMBIENT_I[15:4] > NVM_THRESH_I)) else $error("relay wrong");
   comp_hold_a: assert property (!COMP_POT_SEL_I [*5] |-> $stable(COMP_O))
      else $error("comparator moved while off");
   // Main scenarios reached
   cover property (CMD_STB_O);
   cover property ($rose(COMP_O));
   cover property ($rose(RELAY_O));
endmodule // ssc_port_props
bind ssc_port ssc_port_props chk_u (.CLK_I, .RST_N_I, .CS_N_I, .SDO_OE_N_O, .OBJECT_I, .AMBIENT_I,
   .POT_THRESH_I, .NVM_THRESH_I, .COMP_POT_SEL_I, .REL_NVM_SEL_I, .COMP_O, .RELAY_O, .CMD_O, .CMD_STB_O);
`default_nettype wire

/* File: test/ssc_master.sv */
`timescale 1ns/10ps
`default_nettype none
// Serial master: clock idles low and stands still between frames
module ssc_master #(
   parameter int HALF = 400 // CLK cycles per half period; 400 keeps 8 us
) (
   // Clock
   input  wire logic clk_i,
   // Serial pins
   output var  logic cs_n_o,
   output var  logic sclk_o,
   output var  logic sdi_o,
   input  wire logic sdo_i
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end
   // One frame MSB first; fewer than 32 bits aborts it
   task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rx);
      rx = '0;
      @(negedge clk_i) cs_n_o = 1'b0;
      repeat (HALF) @(negedge clk_i);
      for (int i = 0; i < n; i++) begin
         sdi_o = w[31-i];
         repeat (HALF) @(negedge clk_i);
         sclk_o = 1'b1;
         rx = {rx[30:0], sdo_i};
         repeat (HALF) @(negedge clk_i);
         sclk_o = 1'b0;
      end
      repeat (HALF) @(negedge clk_i);
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o; // Released line must not keep a stale bit
      repeat (HALF) @(negedge clk_i);
   endtask
endmodule // ssc_master
`default_nettype wire

/* File: test/ssc_port_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ssc_port_tb_top;
   import ssc_pkg::*;
   typedef struct {logic [7:0] c, a; logic [15:0] d, q; ssc_cmd_type k; logic rd;} ssc_row_type;
   // Short phases keep the run brief; the port only needs a few CLK each
   localparam int HALF = 20;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, rsel = 1'b0;
   logic        cs_n, sclk, sdi, sdo, sdo_oe_n, stb, comp, relay;
   logic [11:0] pot = 12'hfff, nthr = 12'hfff;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic [31:0] rx;
   ssc_cmd_type cmd, last = CMD_NONE;
   int          fail_count = 0, check_count = 0, stb_cnt = 0, s;
   // Writes, reads of each source, and one unknown code
   ssc_row_type rows [10] = '{
      '{8'h50, 8'h12, 16'ha5c3, 16'h0000, CMD_REG_WRITE, 1'b0}, '{8'h48, 8'h03, 16'h0000, 16'h9ab0, CMD_NONE, 1'b1},
      '{8'h48, 8'h10, 16'h0000, 16'hc3a5, CMD_NONE, 1'b1}, '{8'h1f, 8'h21, 16'h1234, 16'h0000, nvm_write_cmd, 1'b0},
      '{8'h20, 8'h22, 16'hffff, 16'h0000, nvm_erase_cmd, 1'b0}, '{8'h08, 8'h04, 16'h0000, 16'h5a30, CMD_NONE, 1'b1},
      '{8'h08, 8'h30, 16'h0000, 16'h3c5a, CMD_NONE, 1'b1}, '{8'h90, 8'h23, 16'h0001, 16'h0000, nvm_block_write_cmd, 1'b0},
      '{8'ha0, 8'h24, 16'h8000, 16'h0000, nvm_block_erase_cmd, 1'b0}, '{8'hc0, 8'h25, 16'hdead, 16'h0000, CMD_NONE, 1'b0}};
   always #5 clk = ~clk;
   // Count commit strobes mid-cycle, clear of the edge that launches them
   always @(negedge clk) if (stb === 1'b1) stb_cnt++;
   ssc_port dut_u (.CLK_I(clk), .RST_N_I(rst_n), .CS_N_I(cs_n), .SCLK_I(sclk), .SDI_I(sdi), .SDO_O(sdo),
      .SDO_OE_N_O(sdo_oe_n), .OBJECT_I(16'h9ab0), .AMBIENT_I(16'h5a30), .REG_RDATA_I(16'hc3a5),
      .NVM_RDATA_I(16'h3c5a), .POT_THRESH_I(pot), .NVM_THRESH_I(nthr), .COMP_POT_SEL_I(psel),
      .REL_NVM_SEL_I(rsel), .CMD_O(cmd), .ADDR_O(addr), .WDATA_O(wdata), .CMD_STB_O(stb), .COMP_O(comp),
      .RELAY_O(relay));
   ssc_master #(.HALF(HALF)) mst_u (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo));
   task automatic chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog: eleven frames of about 1400 clocks plus the short tests,
   // so 40000 clocks leaves a wide margin
   initial begin
      #400000;
      fail_count++;
      $display("mismatch at %0t: timeout", $time);
      results();
   end
   initial begin
      repeat (5) @(negedge clk);
      chk(cmd === CMD_NONE && addr === 8'h00 && wdata === 16'h0000 && stb === 1'b0 && sdo_oe_n === 1'b1, "reset");
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      for (int r = 0; r < 10; r++) begin
         s = stb_cnt;
         mst_u.xfer({rows[r].c, rows[r].a, rows[r].d}, 32, rx);
         if (rows[r].rd) chk(rx[23:0] === {rows[r].c, rows[r].q}, "read");
         else if (rows[r].k != CMD_NONE) begin
            last = rows[r].k;
            chk(rx[23:0] === {rows[r].c, rows[r].a, rows[r].d[15:8]}, "echo");
            chk(stb_cnt == s + 1 && cmd === last && addr === rows[r].a && wdata === rows[r].d, "commit");
         end
         if (rows[r].rd || rows[r].k == CMD_NONE) chk(stb_cnt == s && cmd === last, "no commit");
         $display("test %0d done", r);
      end
      s = stb_cnt;
      mst_u.xfer(32'h5040_7777, 20, rx);
      chk(stb_cnt == s && cmd === last, "abort");
      $display("test abort done");
      {psel, rsel, pot, nthr} = {2'b11, 12'h9ab, 12'h5a3};
      repeat (6) @(negedge clk);
      chk(comp === 1'b0 && relay === 1'b0, "equal");
      {pot, nthr} = {12'h9aa, 12'h5a2};
      repeat (6) @(negedge clk);
      chk(comp === 1'b1 && relay === 1'b1, "above");
      {psel, rsel} = 2'b00;
      repeat (6) @(negedge clk);
      {pot, nthr} = {12'hfff, 12'hfff};
      repeat (6) @(negedge clk);
      chk(comp === 1'b1 && relay === 1'b1, "hold");
      $display("test compare done");
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      chk(cmd === CMD_NONE && comp === 1'b0 && sdo_oe_n === 1'b1, "reset again");
      rst_n = 1'b1;
      $display("test reset done");
      results();
   end
endmodule // ssc_port_tb_top
`default_nettype wire
